// File: rtl/lptc_pkg.sv
// Function
// [RQ1] latch output goes 1 on set alone, 0 on reset, reset wins over set.
// [RQ2] latch holds its previous output while set and reset are both low.
// [RQ3] pulse generator alternates 1 and 0 for one period each while enabled.
// [RQ4] configuring party keeps the pulse period at 0.10 s or more.
// [RQ5] on-delay starts counting on trigger rise, output 1 when delay reached.
// [RQ6] once started, further trigger changes neither restart nor stop the on-delay.
// [RQ7] on-delay output and elapsed time clear only by reset, reset beats trigger.
// [RQ8] counter moves by one on each rising count edge, ignores falling edges.
// [RQ9] counter counts up when direction is 0, down when it is 1.
// [RQ10] counter stays in 0..9999, saturating at both ends.
// [RQ11] counter output is 1 when value is at or above the threshold.
// [RQ12] counter reset holds value 0000 and output 0, reset beats counting.
// [RQ13] count source must not toggle faster than 5 Hz.
// [RQ14] counter starts from 0000 after every power-up.
// [RQ15] all elapsed times start cleared after power is restored.
// [RQ16] pulse output is 0 while disabled; each enable rise starts a full high phase.
// [RQ17] all timing advances from a common hundredth-of-a-second tick.
package lptc_pkg;
    localparam int CLK_HZ = 20000000;
    localparam int TICK_HZ = 100;
    localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
    localparam int TIME_W = 16;
    localparam int CNT_W = 14;
    localparam logic [CNT_W-1:0] CNT_MAX = 14'h270f;
    localparam logic [CNT_W-1:0] CNT_RESET = 14'h0000;
    localparam logic [TIME_W-1:0] TIME_RESET = 16'h0000;
    localparam logic [TIME_W-1:0] PULSE_MIN = 16'h000a;
    localparam logic [31:0] AXI_DATA_RESET = 32'h00000000;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_PULSE_T = 8'h08;
    localparam logic [7:0] REG_DELAY_T = 8'h0c;
    localparam logic [7:0] REG_THRESH = 8'h10;
    localparam logic [7:0] REG_COUNT = 8'h14;
    localparam logic [7:0] REG_ELAPSED = 8'h18;
    // control bit positions
    localparam int CTRL_SOFT_SET = 0;
    localparam int CTRL_SOFT_RST = 1;
    localparam int CTRL_PULSE_EN = 2;
    localparam int CTRL_TRG = 3;
    localparam int CTRL_TRST = 4;
    localparam int CTRL_CNT = 5;
    localparam int CTRL_DIR = 6;
    localparam int CTRL_CRST = 7;
    localparam int CTRL_USE_PINS = 8;
    localparam int CTRL_W = 9;
    // status bit positions
    localparam int STAT_LATCH = 0;
    localparam int STAT_PULSE = 1;
    localparam int STAT_DELAY = 2;
    localparam int STAT_CNT = 3;
    localparam int STAT_RUNNING = 4;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// File: rtl/lptc_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
module lptc_tick_gen #(
    parameter int DIVIDE = lptc_pkg::TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    output logic tick
);
    import lptc_pkg::*;
    localparam int DW = $clog2(DIVIDE + 1);
    initial begin
        if (DIVIDE < 2) $error("tick divider too small");
    end
    logic [DW-1:0] div_q, div_d;
    logic tick_q, tick_d;
    always_comb begin
        // one shared hundredth tick for every timer [RQ17]
        tick_d = (div_q == DW'(DIVIDE - 1));
        div_d = tick_d ? '0 : div_q + 1'b1;
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            div_q <= '0;
            tick_q <= 1'b0;
        end else begin
            div_q <= div_d;
            tick_q <= tick_d;
        end
    end
    assign tick = tick_q;
endmodule
`default_nettype wire

// File: rtl/lptc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module lptc_sync #(
    parameter int WIDTH = 6
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    import lptc_pkg::*;
    logic [WIDTH-1:0] meta_q, sync_q;
    initial begin
        if (WIDTH < 1) $error("sync width must be positive");
    end
    // first stage read by the second only
    always_ff @(posedge core_clk) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end
    assign sync_out = sync_q;
endmodule
`default_nettype wire

// File: rtl/lptc_top.sv
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module lptc_top #(
    parameter int TICK_DIV = lptc_pkg::TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic pinSet,
    input wire logic pinReset,
    input wire logic pinEnable,
    input wire logic pinTrigger,
    input wire logic pinTimerReset,
    input wire logic pinCount,
    input wire logic pinDir,
    input wire logic pinCountReset,
    output logic latchOut,
    output logic pulseOut,
    output logic delayOut,
    output logic countOut,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import lptc_pkg::*;

    initial begin
        if (TICK_DIV < 2) $error("tick divider below two cycles");
    end

    logic tick;
    logic [7:0] pinsSync;
    lptc_tick_gen #(.DIVIDE(TICK_DIV)) u_lptc_tick_gen (
        .core_clk(core_clk),
        .rst(rst),
        .tick(tick)
    );
    lptc_sync #(.WIDTH(8)) u_lptc_sync (
        .core_clk(core_clk),
        .rst(rst),
        .async_in({pinCountReset, pinDir, pinCount, pinTimerReset, pinTrigger, pinEnable, pinReset, pinSet}),
        .sync_out(pinsSync)
    );

    // ---------------- register file ----------------
    logic [CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [TIME_W-1:0] pulseT_q, pulseT_d, delayT_q, delayT_d;
    logic [CNT_W-1:0] thresh_q, thresh_d;
    logic awPend_q, awPend_d, wPend_q, wPend_d, bvalid_q, bvalid_d;
    logic [7:0] awAddr_q, awAddr_d;
    logic [31:0] wData_q, wData_d;
    logic [3:0] wStrb_q, wStrb_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic doWrite;
    logic awReady_q, awReady_d, wReady_q, wReady_d, arReady_q, arReady_d;

    // ---------------- block state ----------------
    logic latch_q, latch_d;
    logic pulse_q, pulse_d, enPrev_q, enPrev_d;
    logic [TIME_W-1:0] pulseEl_q, pulseEl_d;
    logic delayOut_q, delayOut_d, running_q, running_d, trgPrev_q, trgPrev_d;
    logic [TIME_W-1:0] delayEl_q, delayEl_d;
    logic [CNT_W-1:0] count_q, count_d;
    logic cntPrev_q, cntPrev_d, countOut_q, countOut_d;

    // effective inputs: pins or software, chosen by control bit
    logic sSet, sRst, sEn, sTrg, sTrst, sCnt, sDir, sCrst;
    always_comb begin
        if (ctrl_q[CTRL_USE_PINS]) begin
            {sCrst, sDir, sCnt, sTrst, sTrg, sEn, sRst, sSet} = pinsSync;
        end else begin
            sSet = ctrl_q[CTRL_SOFT_SET];
            sRst = ctrl_q[CTRL_SOFT_RST];
            sEn = ctrl_q[CTRL_PULSE_EN];
            sTrg = ctrl_q[CTRL_TRG];
            sTrst = ctrl_q[CTRL_TRST];
            sCnt = ctrl_q[CTRL_CNT];
            sDir = ctrl_q[CTRL_DIR];
            sCrst = ctrl_q[CTRL_CRST];
        end
    end

    // axi write side: address and data taken in either order
    always_comb begin
        awPend_d = awPend_q;
        wPend_d = wPend_q;
        awAddr_d = awAddr_q;
        wData_d = wData_q;
        wStrb_d = wStrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        ctrl_d = ctrl_q;
        pulseT_d = pulseT_q;
        delayT_d = delayT_q;
        thresh_d = thresh_q;
        if (s_axi_awvalid && !awPend_q) begin
            awPend_d = 1'b1;
            awAddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !wPend_q) begin
            wPend_d = 1'b1;
            wData_d = s_axi_wdata;
            wStrb_d = s_axi_wstrb;
        end
        doWrite = awPend_q && wPend_q && !bvalid_q;
        if (doWrite) begin
            awPend_d = 1'b0;
            wPend_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = RESP_OKAY;
            case (awAddr_q)
                REG_CTRL: begin
                    if (wStrb_q[0]) ctrl_d[7:0] = wData_q[7:0];
                    if (wStrb_q[1]) ctrl_d[CTRL_W-1:8] = wData_q[CTRL_W-1:8];
                end
                REG_PULSE_T: begin
                    if (wStrb_q[0]) pulseT_d[7:0] = wData_q[7:0];
                    if (wStrb_q[1]) pulseT_d[15:8] = wData_q[15:8];
                end
                REG_DELAY_T: begin
                    if (wStrb_q[0]) delayT_d[7:0] = wData_q[7:0];
                    if (wStrb_q[1]) delayT_d[15:8] = wData_q[15:8];
                end
                REG_THRESH: begin
                    if (wStrb_q[0]) thresh_d[7:0] = wData_q[7:0];
                    if (wStrb_q[1]) thresh_d[CNT_W-1:8] = wData_q[CNT_W-1:8];
                    // threshold range 0..9999 [RQ11]
                    if (thresh_d > CNT_MAX) thresh_d = CNT_MAX;
                end
                REG_STATUS, REG_COUNT, REG_ELAPSED: bresp_d = RESP_OKAY;
                default: bresp_d = RESP_SLVERR;
            endcase
        end
        if (bvalid_q && s_axi_bready) bvalid_d = 1'b0;
        awReady_d = !awPend_d;
        wReady_d = !wPend_d;
    end

    // axi read side
    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (s_axi_arvalid && !rvalid_q) begin
            rvalid_d = 1'b1;
            rresp_d = RESP_OKAY;
            rdata_d = AXI_DATA_RESET;
            case (s_axi_araddr)
                REG_CTRL: rdata_d[CTRL_W-1:0] = ctrl_q;
                REG_STATUS: begin
                    rdata_d[STAT_LATCH] = latch_q;
                    rdata_d[STAT_PULSE] = pulse_q;
                    rdata_d[STAT_DELAY] = delayOut_q;
                    rdata_d[STAT_CNT] = countOut_q;
                    rdata_d[STAT_RUNNING] = running_q;
                end
                REG_PULSE_T: rdata_d[TIME_W-1:0] = pulseT_q;
                REG_DELAY_T: rdata_d[TIME_W-1:0] = delayT_q;
                REG_THRESH: rdata_d[CNT_W-1:0] = thresh_q;
                REG_COUNT: rdata_d[CNT_W-1:0] = count_q;
                REG_ELAPSED: rdata_d[TIME_W-1:0] = delayEl_q;
                default: rresp_d = RESP_SLVERR;
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        arReady_d = !rvalid_d;
    end

    // latch
    always_comb begin
        latch_d = latch_q; // [RQ2]
        if (sRst) latch_d = 1'b0; // [RQ1]
        else if (sSet) latch_d = 1'b1; // [RQ1]
    end

    // pulse generator; periods under the minimum are not served
    logic [TIME_W-1:0] pulsePeriod;
    always_comb begin
        pulsePeriod = (pulseT_q < PULSE_MIN) ? PULSE_MIN : pulseT_q; // [RQ4]
        enPrev_d = sEn;
        pulse_d = pulse_q;
        pulseEl_d = pulseEl_q;
        if (!sEn) begin
            pulse_d = 1'b0; // [RQ16]
            pulseEl_d = TIME_RESET; // [RQ3]
        end else if (!enPrev_q) begin
            pulse_d = 1'b1; // [RQ16]
            pulseEl_d = TIME_RESET;
        end else if (tick) begin
            if (pulseEl_q + 1'b1 >= pulsePeriod) begin
                pulse_d = !pulse_q; // [RQ3]
                pulseEl_d = TIME_RESET;
            end else begin
                pulseEl_d = pulseEl_q + 1'b1; // [RQ17]
            end
        end
    end

    // retentive on-delay
    always_comb begin
        trgPrev_d = sTrg;
        running_d = running_q;
        delayOut_d = delayOut_q;
        delayEl_d = delayEl_q;
        if (sTrst) begin
            running_d = 1'b0; // [RQ7]
            delayOut_d = 1'b0;
            delayEl_d = TIME_RESET;
        end else begin
            if (sTrg && !trgPrev_q && !running_q && !delayOut_q) running_d = 1'b1; // [RQ5] [RQ6]
            if (running_q && tick) begin
                if (delayEl_q + 1'b1 >= delayT_q) begin
                    delayOut_d = 1'b1; // [RQ5]
                    running_d = 1'b0;
                    delayEl_d = delayT_q;
                end else begin
                    delayEl_d = delayEl_q + 1'b1; // [RQ17]
                end
            end
            if (running_q && delayT_q == TIME_RESET) begin
                delayOut_d = 1'b1;
                running_d = 1'b0;
            end
        end
    end

    // up/down counter
    always_comb begin
        cntPrev_d = sCnt;
        count_d = count_q;
        if (sCrst) begin
            count_d = CNT_RESET; // [RQ12]
        end else if (sCnt && !cntPrev_q) begin // [RQ8]
            if (!sDir) begin
                if (count_q != CNT_MAX) count_d = count_q + 1'b1; // [RQ9] [RQ10]
            end else begin
                if (count_q != CNT_RESET) count_d = count_q - 1'b1; // [RQ9] [RQ10]
            end
        end
        countOut_d = !sCrst && (count_d >= thresh_q); // [RQ11] [RQ12]
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_q <= '0;
            pulseT_q <= PULSE_MIN;
            delayT_q <= TIME_RESET;
            thresh_q <= CNT_RESET;
            awPend_q <= 1'b0;
            wPend_q <= 1'b0;
            awAddr_q <= '0;
            wData_q <= AXI_DATA_RESET;
            wStrb_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= AXI_DATA_RESET;
            rresp_q <= RESP_OKAY;
            awReady_q <= 1'b1;
            wReady_q <= 1'b1;
            arReady_q <= 1'b1;
        end else begin
            ctrl_q <= ctrl_d;
            pulseT_q <= pulseT_d;
            delayT_q <= delayT_d;
            thresh_q <= thresh_d;
            awPend_q <= awPend_d;
            wPend_q <= wPend_d;
            awAddr_q <= awAddr_d;
            wData_q <= wData_d;
            wStrb_q <= wStrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            awReady_q <= awReady_d;
            wReady_q <= wReady_d;
            arReady_q <= arReady_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            latch_q <= 1'b0;
        end else begin
            latch_q <= latch_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pulse_q <= 1'b0;
            enPrev_q <= 1'b0;
            pulseEl_q <= TIME_RESET; // [RQ15]
        end else begin
            pulse_q <= pulse_d;
            enPrev_q <= enPrev_d;
            pulseEl_q <= pulseEl_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            delayOut_q <= 1'b0;
            running_q <= 1'b0;
            trgPrev_q <= 1'b0;
            delayEl_q <= TIME_RESET; // [RQ15]
        end else begin
            delayOut_q <= delayOut_d;
            running_q <= running_d;
            trgPrev_q <= trgPrev_d;
            delayEl_q <= delayEl_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            count_q <= CNT_RESET; // [RQ14]
            cntPrev_q <= 1'b0;
            countOut_q <= 1'b0;
        end else begin
            count_q <= count_d;
            cntPrev_q <= cntPrev_d;
            countOut_q <= countOut_d;
        end
    end

    // ready kept in its own flop so every port leaves a register
    assign s_axi_awready = awReady_q;
    assign s_axi_wready = wReady_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arReady_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign latchOut = latch_q;
    assign pulseOut = pulse_q;
    assign delayOut = delayOut_q;
    assign countOut = countOut_q;
endmodule
`default_nettype wire

// File: sim/lptc_switches.sv
`timescale 1ns/1ps
`default_nettype none
module lptc_switches #(
    parameter int MIN_HOLD = 4
) (
    input wire logic core_clk,
    input wire logic [7:0] want,
    output logic [7:0] pins
);
    int held = 0;
    initial pins = 8'h00;
    // contacts move on the clock; the count contact is rate limited by a hold count
    always @(posedge core_clk) begin
        held <= (held < MIN_HOLD) ? held + 1 : held;
        pins[7:6] <= want[7:6];
        pins[4:0] <= want[4:0];
        if (want[5] != pins[5] && held >= MIN_HOLD) begin
            pins[5] <= want[5];
            held <= 0;
        end
    end
endmodule
`default_nettype wire

// File: sim/lptc_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module lptc_top_props
import lptc_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic latchOut,
    input wire logic pulseOut,
    input wire logic delayOut,
    input wire logic countOut,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    logic awGot_q, wGot_q;
    logic [7:0] aw_q;
    logic [31:0] w_q;
    logic [8:0] ctrl_q;
    wire awFire = s_axi_awvalid && s_axi_awready;
    wire wFire = s_axi_wvalid && s_axi_wready;
    wire bothIn = (awFire || awGot_q) && (wFire || wGot_q);
    wire [7:0] addrNow = awFire ? s_axi_awaddr : aw_q;
    wire [31:0] dataNow = wFire ? s_axi_wdata : w_q;
    // mirror leads the slave, so checks give the block a few cycles to follow
    wire [8:0] ctrlNow = (bothIn && addrNow == REG_CTRL) ? dataNow[8:0] : ctrl_q;
    wire regMode = !ctrlNow[CTRL_USE_PINS];
    always_ff @(posedge core_clk) begin
        if (rst) begin
            awGot_q <= 1'b0;
            wGot_q <= 1'b0;
            aw_q <= 8'h00;
            w_q <= 32'h00000000;
            ctrl_q <= 9'h000;
        end else begin
            awGot_q <= (awGot_q || awFire) && !bothIn;
            wGot_q <= (wGot_q || wFire) && !bothIn;
            aw_q <= addrNow;
            w_q <= dataNow;
            ctrl_q <= ctrlNow;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    chk_reset_outs: assert property (disable iff (1'b0)
        rst |=> !latchOut && !pulseOut && !delayOut && !countOut) else $error("outputs not cleared by reset");
    chk_latch_set: assert property (
        (regMode && ctrlNow[CTRL_SOFT_SET] && !ctrlNow[CTRL_SOFT_RST]) [*4] |-> latchOut) else $error("latch not set");
    chk_latch_reset: assert property (
        (regMode && ctrlNow[CTRL_SOFT_RST]) [*4] |-> !latchOut) else $error("latch not reset");
    chk_latch_hold: assert property (
        (regMode && !ctrlNow[CTRL_SOFT_SET] && !ctrlNow[CTRL_SOFT_RST]) [*4] |-> $stable(latchOut))
        else $error("latch changed while idle");
    chk_pulse_off: assert property (
        (regMode && !ctrlNow[CTRL_PULSE_EN]) [*4] |-> !pulseOut) else $error("pulse high while disabled");
    chk_delay_clear: assert property (
        (regMode && ctrlNow[CTRL_TRST]) [*4] |-> !delayOut) else $error("delay output high in reset");
    chk_count_clear: assert property (
        (regMode && ctrlNow[CTRL_CRST]) [*4] |-> !countOut) else $error("count output high in reset");
    chk_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
    chk_write_done: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write response not released");
    cover property ($rose(latchOut));
    cover property ($rose(pulseOut));
    cover property ($rose(delayOut));
    cover property ($rose(countOut));
endmodule
bind lptc_top lptc_top_props #(.TICK_DIV(TICK_DIV)) u_lptc_top_props (.core_clk, .rst, .latchOut, .pulseOut,
    .delayOut, .countOut, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
`default_nettype wire

// File: sim/latch_pulse_timer_counter_blocks_tb.sv
`timescale 1ns/1ps
`default_nettype none
module latch_pulse_timer_counter_blocks_tb;
    import lptc_pkg::*;
    localparam int DIV = 10;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, want = 8'h00, pins;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic latchOut, pulseOut, delayOut, countOut;
    logic [1:0] latSeq [4] = '{2'h1, 2'h0, 2'h3, 2'h0};
    logic latExp [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    int nFail = 0;
    int comparisons = 0;
    int n;
    always #25 core_clk = ~core_clk;
    // count contact levels last ten ticks, so it never toggles above 5 Hz
    lptc_switches #(.MIN_HOLD(10 * DIV)) u_lptc_switches (.core_clk, .want, .pins);
    lptc_top #(.TICK_DIV(DIV)) u_lptc_top (.core_clk, .rst, .pinSet(pins[0]), .pinReset(pins[1]),
        .pinEnable(pins[2]), .pinTrigger(pins[3]), .pinTimerReset(pins[4]), .pinCount(pins[5]),
        .pinDir(pins[6]), .pinCountReset(pins[7]), .latchOut, .pulseOut, .delayOut, .countOut,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            nFail++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
    endtask
    // bready and rready stay high, so a new call never collides with a release
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
        bit ad;
        bit wd;
        ad = 1'b0;
        wd = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge core_clk);
            ad = ad || s_axi_awready;
            wd = wd || s_axi_wready;
            s_axi_awvalid <= !ad;
            s_axi_wvalid <= !wd;
        end
        do @(posedge core_clk); while (!s_axi_bvalid);
        rs = s_axi_bresp;
    endtask
    task automatic axiRead(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge core_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge core_clk); while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        axiRead(a);
        chk(rd, e);
        chk({30'h0, rs}, {30'h0, r});
    endtask
    task automatic cnt(input logic dn);
        axiWrite(REG_CTRL, {25'h0, dn, 6'h20});
        axiWrite(REG_CTRL, {25'h0, dn, 6'h00});
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, nFail);
        if (nFail == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        nFail++;
        finish_test();
    end
    initial begin
        cyc(6);
        rst <= 1'b0;
        chk({28'h0, latchOut, pulseOut, delayOut, countOut}, 32'h0);
        rdChk(REG_COUNT, 32'h0, RESP_OKAY);
        rdChk(REG_ELAPSED, 32'h0, RESP_OKAY);
        rdChk(REG_PULSE_T, 32'h0000000a, RESP_OKAY);
        rdChk(8'h1c, 32'h0, RESP_SLVERR);
        for (int i = 0; i < 4; i++) begin
            axiWrite(REG_CTRL, {30'h0, latSeq[i]});
            cyc(3);
            chk(latchOut, latExp[i]);
        end
        axiWrite(REG_THRESH, 32'hffff);
        rdChk(REG_THRESH, 32'h270f, RESP_OKAY);
        axiWrite(REG_THRESH, 32'h3);
        cnt(1'b0);
        cnt(1'b0);
        chk(countOut, 1'b0);
        cnt(1'b0);
        cyc(2);
        chk(countOut, 1'b1);
        rdChk(REG_COUNT, 32'h3, RESP_OKAY);
        for (int i = 0; i < 4; i++)
            cnt(1'b1);
        rdChk(REG_COUNT, 32'h0, RESP_OKAY);
        chk(countOut, 1'b0);
        axiWrite(REG_THRESH, 32'h0);
        cyc(3);
        chk(countOut, 1'b1);
        axiWrite(REG_CTRL, 32'ha0);
        cyc(3);
        chk(countOut, 1'b0);
        rdChk(REG_COUNT, 32'h0, RESP_OKAY);
        axiWrite(REG_CTRL, 32'h4);
        cyc(3);
        chk(pulseOut, 1'b1);
        while (pulseOut) @(posedge core_clk);
        for (n = 0; !pulseOut; n++) @(posedge core_clk);
        chk(32'(n), 32'(10 * DIV));
        for (n = 0; pulseOut; n++) @(posedge core_clk);
        chk(32'(n), 32'(10 * DIV));
        axiWrite(REG_CTRL, 32'h0);
        cyc(150);
        chk(pulseOut, 1'b0);
        axiWrite(REG_DELAY_T, 32'h8);
        axiWrite(REG_CTRL, 32'h8);
        axiWrite(REG_CTRL, 32'h0);
        cyc(40);
        chk(delayOut, 1'b0);
        axiWrite(REG_CTRL, 32'h8);
        axiWrite(REG_CTRL, 32'h0);
        cyc(44);
        chk(delayOut, 1'b1);
        rdChk(REG_STATUS, 32'h0000000c, RESP_OKAY);
        axiWrite(REG_CTRL, 32'h18);
        cyc(3);
        chk(delayOut, 1'b0);
        rdChk(REG_ELAPSED, 32'h0, RESP_OKAY);
        axiWrite(REG_CTRL, 32'h0);
        cyc(120);
        chk(delayOut, 1'b0);
        axiWrite(REG_CTRL, 32'h100);
        for (int i = 0; i < 4; i++) begin
            want <= {6'h0, latSeq[i]};
            cyc(6);
            chk(latchOut, latExp[i]);
        end
        want <= 8'h0c;
        cyc(6);
        chk(pulseOut, 1'b1);
        want <= 8'h2c;
        cyc(6);
        rdChk(REG_COUNT, 32'h1, RESP_OKAY);
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        rdChk(REG_COUNT, 32'h0, RESP_OKAY);
        rdChk(REG_ELAPSED, 32'h0, RESP_OKAY);
        finish_test();
    end
endmodule
`default_nettype wire
